/* core/sram_port_pkg.sv */
package sram_port_pkg;
    // default organisation: 128K words, four lanes of nine bits
    localparam int WORDS_DEFAULT     = 131072;
    localparam int LANES_DEFAULT     = 4;
    localparam int LANE_BITS_DEFAULT = 9;
    // output register reset value
    localparam logic [35:0] READ_RESET_VALUE = 36'h0_0000_0000;
    // read latency in cycles from the registered edge
    localparam int READ_LATENCY      = 1;
    // synchroniser depth constant; not used, the output enable pin gates the drivers directly
    localparam int OE_SYNC_STAGES    = 3;

    typedef enum logic [1:0] {
        CYC_IDLE  = 2'b00,
        CYC_READ  = 2'b01,
        CYC_WRITE = 2'b10
    } cycle_kind_t;
endpackage

/* core/sram_array.sv */
module sram_array
    import sram_port_pkg::*;
#(
    parameter int WORDS     = WORDS_DEFAULT,
    parameter int LANES     = LANES_DEFAULT,
    parameter int LANE_BITS = LANE_BITS_DEFAULT,
    parameter int AW        = $clog2(WORDS)
) (
    input  wire logic                       sys_clk_i,
    input  wire logic                       wr_i,
    input  wire logic [LANES-1:0]           lane_we_i,
    input  wire logic [AW-1:0]              wr_addr_i,
    input  wire logic [LANES*LANE_BITS-1:0] wr_data_i,
    input  wire logic                       rd_i,
    input  wire logic [AW-1:0]              rd_addr_i,
    output logic      [LANES*LANE_BITS-1:0] rd_data_o
);
    // one bank per byte lane, so every bank has a single writing process
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_BITS-1:0] bank [WORDS];

            always_ff @(posedge sys_clk_i) begin
                if (wr_i && lane_we_i[g]) begin
                    bank[wr_addr_i] <= wr_data_i[g*LANE_BITS +: LANE_BITS];
                end
            end

            // unregistered read; caller registers the word
            assign rd_data_o[g*LANE_BITS +: LANE_BITS] = rd_i ? bank[rd_addr_i] : '0;
        end
    endgenerate
endmodule

/* core/late_write_sync_sram_port.sv */
module late_write_sync_sram_port
    import sram_port_pkg::*;
#(
    parameter int WORDS     = WORDS_DEFAULT,
    parameter int LANES     = LANES_DEFAULT,
    parameter int LANE_BITS = LANE_BITS_DEFAULT,
    parameter int AW        = $clog2(WORDS),
    parameter int DW        = LANES * LANE_BITS
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rstn_i,
    input  wire logic [AW-1:0]    addr_in_i,
    input  wire logic             write_strobe_n_i,
    input  wire logic [LANES-1:0] byte_write_en_n_i,
    input  wire logic             chip_sel_n_i,
    input  wire logic             out_en_n_i,
    input  wire logic [DW-1:0]    data_io_i,
    output logic      [DW-1:0]    data_io_o,
    output logic      [DW-1:0]    data_io_oe_o
);
    // registered address and control stage
    logic [AW-1:0]    addr_q;
    logic [LANES-1:0] lanes_q;
    cycle_kind_t      kind_q;
    logic [AW-1:0]    next_addr_q;
    logic [LANES-1:0] next_lanes_q;
    cycle_kind_t      next_kind_q;

    // read output register, drive flag and array controls
    logic [DW-1:0]    read_q;
    logic             drive_q;
    logic [DW-1:0]    next_read_q;
    logic             next_drive_q;
    logic [DW-1:0]    array_rd;
    logic             array_wr;
    logic             array_rd_en;

    always_comb begin
        next_addr_q  = addr_in_i;
        next_lanes_q = '0;
        next_kind_q  = CYC_IDLE;
        if (!chip_sel_n_i) begin
            if (!write_strobe_n_i) begin
                next_kind_q  = CYC_WRITE;
                next_lanes_q = ~byte_write_en_n_i;
            end else begin
                next_kind_q  = CYC_READ;
            end
        end
    end

    // pipeline state resets; the array contents never do
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_q  <= '0;
            lanes_q <= '0;
            kind_q  <= CYC_IDLE;
        end else begin
            addr_q  <= next_addr_q;
            lanes_q <= next_lanes_q;
            kind_q  <= next_kind_q;
        end
    end

    assign array_wr = (kind_q == CYC_WRITE);
    assign array_rd_en = (next_kind_q == CYC_READ);

    sram_array #(
        .WORDS     (WORDS),
        .LANES     (LANES),
        .LANE_BITS (LANE_BITS),
        .AW        (AW)
    ) u_array (
        .sys_clk_i (sys_clk_i),
        .wr_i      (array_wr),
        .lane_we_i (lanes_q),
        .wr_addr_i (addr_q),
        .wr_data_i (data_io_i),
        .rd_i      (array_rd_en),
        .rd_addr_i (addr_in_i),
        .rd_data_o (array_rd)
    );

    // read word loaded on the same edge that registers the read
    always_comb begin
        next_read_q  = read_q;
        next_drive_q = 1'b0;
        if (array_rd_en) begin
            // bypass: a read right after a write to the same word sees new lanes
            next_read_q = array_rd;
            if (array_wr && (addr_q == addr_in_i)) begin
                for (int i = 0; i < LANES; i++) begin
                    if (lanes_q[i]) begin
                        next_read_q[i*LANE_BITS +: LANE_BITS] = data_io_i[i*LANE_BITS +: LANE_BITS];
                    end
                end
            end
            next_drive_q = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            read_q  <= READ_RESET_VALUE[DW-1:0];
            drive_q <= 1'b0;
        end else begin
            read_q  <= next_read_q;
            drive_q <= next_drive_q;
        end
    end

    assign data_io_o    = read_q;
    assign data_io_oe_o = {DW{drive_q && !out_en_n_i}};

    // expands active-high lane enables into a mask over the whole word
    function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] lanes);
        logic [DW-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i*LANE_BITS +: LANE_BITS] = {LANE_BITS{lanes[i]}};
        end
        return m;
    endfunction

    // one cycle, used by several checks
    sequence s_sel_read;
        !chip_sel_n_i && write_strobe_n_i;
    endsequence

    sequence s_sel_write;
        !chip_sel_n_i && !write_strobe_n_i;
    endsequence

    // write registered, then a read of the same word on the very next edge
    sequence s_write_then_read;
        s_sel_write ##1 (s_sel_read && addr_in_i == $past(addr_in_i));
    endsequence

    chk_read_drive_next: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_sel_read |=> drive_q)
        else $error("selected read did not drive next cycle");

    chk_desel_no_drive: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        chip_sel_n_i |=> !drive_q)
        else $error("deselected cycle drove data");

    chk_write_no_drive: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_sel_write |=> !drive_q && array_wr)
        else $error("write cycle drove data or skipped write");

    chk_write_late_data: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_sel_write |=> (lanes_q == ~$past(byte_write_en_n_i)) && (addr_q == $past(addr_in_i)))
        else $error("late write controls not held one cycle");

    chk_read_no_lanes: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_sel_read |=> lanes_q == '0 && !array_wr)
        else $error("read cycle enabled a lane");

    chk_oe_gates_bus: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        out_en_n_i |-> data_io_oe_o == '0)
        else $error("bus driven with output enable high");

    chk_oe_follows_drive: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (!out_en_n_i && drive_q) |-> data_io_oe_o == {DW{1'b1}})
        else $error("bus not driven for read");

    chk_desel_no_write: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (chip_sel_n_i || write_strobe_n_i) |=> !array_wr)
        else $error("write without strobe and select");

    chk_read_stable_idle: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        chip_sel_n_i |=> $stable(read_q))
        else $error("read register changed while idle");

    // a read right behind a write to the same word must see the new lanes
    chk_bypass_lanes: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_write_then_read |=> ((read_q ^ $past(data_io_i)) & lane_mask(~$past(byte_write_en_n_i, 2))) == '0)
        else $error("read after write missed the new lanes");

    // the last read word stands through write cycles
    chk_write_keeps_read: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_sel_write |=> $stable(read_q))
        else $error("write cycle changed the read register");

    // all enables low writes the whole word
    chk_full_word: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (!chip_sel_n_i && !write_strobe_n_i && byte_write_en_n_i == '0)
            |=> array_wr && lane_mask(lanes_q) == {DW{1'b1}})
        else $error("full-word write missed a lane");

    // deselected edge reads nothing from the array
    chk_desel_no_read: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        chip_sel_n_i |-> !array_rd_en)
        else $error("array read while deselected");
endmodule

/* verif/sram_ctrl_model.sv */
// controller side: one call per clock cycle, launched 1 ns after the rising edge
module sram_ctrl_model (
    input  wire logic        sys_clk_i,
    output logic      [16:0] addr_in_o,
    output logic             write_strobe_n_o,
    output logic      [3:0]  byte_write_en_n_o,
    output logic             chip_sel_n_o,
    output logic             out_en_n_o,
    output logic      [35:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus state at time zero, deselected
    initial begin
        addr_in_o         = 17'h0_0000;
        write_strobe_n_o  = 1'b1;
        byte_write_en_n_o = 4'hF;
        chip_sel_n_o      = 1'b1;
        out_en_n_o        = 1'b0;
        data_o            = 36'h0_0000_0000;
    end

    // controls held for the whole cycle
    // write data only in the cycle after its controls, else inverted so stale data never matches
    // out_en_n_o set by the bench; single clock stands for the true/complement pair
    task automatic cyc(input logic cs_n, input logic sw_n, input logic [3:0] be_n,
                       input logic [16:0] a, input logic dv, input logic [35:0] d);
        @(posedge sys_clk_i);
        #1;
        chip_sel_n_o      = cs_n;
        write_strobe_n_o  = sw_n;
        byte_write_en_n_o = be_n;
        addr_in_o         = a;
        data_o            = dv ? d : ~data_o;
    endtask
endmodule

/* verif/tb_top.sv */
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s exp=%h got=%h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic [16:0] addr;
    logic        sw_n, cs_n, oe_n;
    logic [3:0]  be_n;
    logic [35:0] ctrl_d, rdata, oe, exp;
    logic [35:0] bus;
    int          fails      = 0;
    int          n_compared = 0;
    localparam logic [35:0] ALL = 36'hF_FFFF_FFFF;

    always #4 sys_clk_i = ~sys_clk_i;
    // wire level: device drives while enabled, else controller
    assign bus = oe[0] ? rdata : ctrl_d;

    sram_ctrl_model u_sram_ctrl_model (.sys_clk_i(sys_clk_i), .addr_in_o(addr), .write_strobe_n_o(sw_n),
        .byte_write_en_n_o(be_n), .chip_sel_n_o(cs_n), .out_en_n_o(oe_n), .data_o(ctrl_d));
    late_write_sync_sram_port u_late_write_sync_sram_port (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .addr_in_i(addr), .write_strobe_n_i(sw_n), .byte_write_en_n_i(be_n), .chip_sel_n_i(cs_n),
        .out_en_n_i(oe_n), .data_io_i(bus), .data_io_o(rdata), .data_io_oe_o(oe));

    task automatic chk_rd(input logic [35:0] e);
        `CHK("read data", e, rdata)
        `CHK("drive enable", ALL, oe)
    endtask

    // back-to-back writes, then a read of the word written one edge earlier
    task automatic t_full();
        u_sram_ctrl_model.cyc(0, 0, 4'h0, 17'h0_0001, 0, 0);
        u_sram_ctrl_model.cyc(0, 0, 4'h0, 17'h1_FFFF, 1, 36'h1_2345_6789);
        u_sram_ctrl_model.cyc(0, 1, 4'hF, 17'h1_FFFF, 1, 36'hA_BCDE_F012);
        u_sram_ctrl_model.cyc(0, 1, 4'h5, 17'h0_0001, 0, 0);
        chk_rd(36'hA_BCDE_F012);
        u_sram_ctrl_model.cyc(1, 1, 4'hF, 17'h0_0000, 0, 0);
        chk_rd(36'h1_2345_6789);
        u_sram_ctrl_model.cyc(1, 1, 4'hF, 17'h0_0000, 0, 0);
        `CHK("idle drive", 36'h0, oe)
        $display("t_full done");
    endtask

    // one lane at a time over a cleared word
    task automatic t_lanes();
        exp = 36'h0;
        u_sram_ctrl_model.cyc(0, 0, 4'h0, 17'h0_0055, 0, 0);
        u_sram_ctrl_model.cyc(1, 1, 4'hF, 17'h0_0000, 1, 36'h0);
        for (int i = 0; i < 4; i++) begin
            u_sram_ctrl_model.cyc(0, 0, ~(4'h1 << i), 17'h0_0055, 0, 0);
            u_sram_ctrl_model.cyc(0, 1, 4'h0, 17'h0_0055, 1, ALL);
            exp[9*i +: 9] = 9'h1FF;
            u_sram_ctrl_model.cyc(1, 1, 4'hF, 17'h0_0000, 0, 0);
            chk_rd(exp);
        end
        $display("t_lanes done");
    endtask

    // a write with select high must leave the word alone
    task automatic t_desel();
        u_sram_ctrl_model.cyc(1, 0, 4'h0, 17'h0_0055, 0, 0);
        u_sram_ctrl_model.cyc(1, 1, 4'hF, 17'h0_0000, 1, 36'h0);
        `CHK("desel drive", 36'h0, oe)
        u_sram_ctrl_model.cyc(0, 1, 4'hF, 17'h0_0055, 0, 0);
        u_sram_ctrl_model.cyc(1, 1, 4'hF, 17'h0_0000, 0, 0);
        chk_rd(ALL);
        $display("t_desel done");
    endtask

    // output enable gates the drivers between clock edges
    task automatic t_oe();
        u_sram_ctrl_model.out_en_n_o = 1'b1;
        u_sram_ctrl_model.cyc(0, 1, 4'hF, 17'h1_FFFF, 0, 0);
        u_sram_ctrl_model.cyc(1, 1, 4'hF, 17'h0_0000, 0, 0);
        `CHK("gated drive", 36'h0, oe)
        u_sram_ctrl_model.out_en_n_o = 1'b0;
        #1 chk_rd(36'hA_BCDE_F012);
        $display("t_oe done");
    endtask

    task automatic summarize();
        $display("compared=%0d mismatches=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        fails++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge sys_clk_i);
        #1;
        `CHK("reset data", 36'h0, rdata)
        `CHK("reset drive", 36'h0, oe)
        rstn_i = 1'b1;
        t_full();
        t_lanes();
        t_desel();
        t_oe();
        summarize();
    end
endmodule
